// [rtl/config_access_cfg.svh]
`ifndef CONFIG_ACCESS_CFG_SVH
`define CONFIG_ACCESS_CFG_SVH

// access port base addresses chosen by the latched strap
`define CFG_BASE_STRAP0     10'h3F0
`define CFG_BASE_STRAP1     10'h370
// data window sits one above the key/index address
`define CFG_DATA_OFFSET     10'h001
// key bytes
`define CFG_KEY_ENTER       8'h55
`define CFG_KEY_EXIT        8'hAA
// number of configuration registers and highest index
`define CFG_REG_COUNT       48
`define CFG_REG_LAST        8'h2F
// reset value of the index select register
`define CFG_INDEX_RESET     8'h00
// default contents of the register array at power up
`define CFG_DEFAULT_VALUE   8'h00

`endif

// [rtl/config_access_pkg.sv]
package config_access_pkg;

    // run state versus configuration state
    typedef enum logic {
        RUN_STATE,
        CONFIG_STATE
    } access_state_t;

    typedef logic [7:0] cfg_byte_t;

endpackage

// [rtl/config_access_state_machine.sv]
`timescale 1ns/1ps
`include "config_access_cfg.svh"

module config_access_state_machine
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         baseSelectStrap,
    input  wire logic [9:0]   ioAddr,
    input  wire logic [7:0]   ioWriteData,
    input  wire logic         ioWrite,
    input  wire logic         ioRead,
    output logic      [7:0]   ioReadData,
    output logic              ioReadValid,
    output logic              configActive,
    output logic              baseSelectLatched,
    output logic      [383:0] configRegisterFlat
);

    // pin inputs other than rst pass two flops before any logic reads them
    logic        strapMeta_q;
    logic        strapSync_q;
    logic [9:0]  addrMeta_q;
    logic [9:0]  addrSync_q;
    logic [7:0]  wdataMeta_q;
    logic [7:0]  wdataSync_q;
    logic [1:0]  strobeMeta_q;
    logic [1:0]  strobeSync_q;
    logic [1:0]  strobePrev_q;

    // state group
    config_access_pkg::access_state_t state_q;
    config_access_pkg::access_state_t state_d;
    logic                          rstSeen_q;
    logic                          rstSeen_d;
    logic                          baseLatched_q;
    logic                          baseLatched_d;
    config_access_pkg::cfg_byte_t  indexSelect_q;
    config_access_pkg::cfg_byte_t  indexSelect_d;
    logic [7:0]                    readData_q;
    logic [7:0]                    readData_d;
    logic                          readValid_q;
    logic                          readValid_d;

    // array is never reset so contents survive a reset; defaults load at power up only
    config_access_pkg::cfg_byte_t  configRegisterArray [0:`CFG_REG_COUNT-1]
                                   = '{default: `CFG_DEFAULT_VALUE};
    logic                          arrayWrite;

    // decoded strobes, one pulse per host access
    logic        writePulse;
    logic        readPulse;
    logic [9:0]  baseAddr;
    logic        hitKey;
    logic        hitData;
    logic        indexInRange;
    // qualified accesses per port and direction
    logic        keyWrite;
    logic        dataWrite;
    logic        keyRead;
    logic        dataRead;
    logic        keyIsEnter;
    logic        keyIsExit;

    // synchronisers for the asynchronous isa pins
    // address and data pass the same two flops, so they agree with the strobe edge
    always_ff @(posedge clk)
    begin
        strapMeta_q  <= baseSelectStrap;
        strapSync_q  <= strapMeta_q;
        addrMeta_q   <= ioAddr;
        addrSync_q   <= addrMeta_q;
        wdataMeta_q  <= ioWriteData;
        wdataSync_q  <= wdataMeta_q;
        strobeMeta_q <= {ioRead, ioWrite};
        strobeSync_q <= strobeMeta_q;
        strobePrev_q <= strobeSync_q;
    end

    // rising edge of each synchronised strobe marks one access
    // a strobe held high for many cycles still counts once
    assign writePulse   = strobeSync_q[0] & ~strobePrev_q[0];
    assign readPulse    = strobeSync_q[1] & ~strobePrev_q[1];
    assign baseAddr     = baseLatched_q ? `CFG_BASE_STRAP1 : `CFG_BASE_STRAP0;
    assign hitKey       = (addrSync_q == baseAddr);
    assign hitData      = (addrSync_q == baseAddr + `CFG_DATA_OFFSET);
    assign indexInRange = (indexSelect_q <= `CFG_REG_LAST);

    // one qualified strobe per port and direction
    assign keyWrite     = writePulse & hitKey;
    assign dataWrite    = writePulse & hitData;
    assign keyRead      = readPulse & hitKey;
    assign dataRead     = readPulse & hitData;

    // key bytes compared on synchronised data, settled before the strobe edge
    assign keyIsEnter   = (wdataSync_q == `CFG_KEY_ENTER);
    assign keyIsExit    = (wdataSync_q == `CFG_KEY_EXIT);

    // next-state logic for the access state machine and port answers
    always_comb
    begin
        state_d       = state_q;
        rstSeen_d     = rstSeen_q;
        baseLatched_d = baseLatched_q;
        indexSelect_d = indexSelect_q;
        readData_d    = readData_q;
        readValid_d   = 1'b0;
        arrayWrite    = 1'b0;
        // strap taken on the first clock after reset releases
        if (!rstSeen_q)
        begin
            rstSeen_d     = 1'b1;
            baseLatched_d = strapSync_q;
        end
        unique case (state_q)
            config_access_pkg::RUN_STATE:
            begin
                // index and data ports stay silent here
                if (keyWrite && keyIsEnter)
                begin
                    state_d = config_access_pkg::CONFIG_STATE;
                end
            end
            config_access_pkg::CONFIG_STATE:
            begin
                // the exit key shares the index address, so it is decoded first
                if (keyWrite)
                begin
                    if (keyIsExit)
                    begin
                        state_d = config_access_pkg::RUN_STATE;
                    end
                    else
                    begin
                        indexSelect_d = wdataSync_q;
                    end
                end
                else if (dataWrite)
                begin
                    // writes past the last index are dropped rather than wrapped
                    arrayWrite = indexInRange;
                end
                else if (keyRead)
                begin
                    readData_d  = indexSelect_q;
                    readValid_d = 1'b1;
                end
                else if (dataRead)
                begin
                    // out-of-range index reads as zero rather than aliasing
                    readData_d  = indexInRange ? configRegisterArray[indexSelect_q[5:0]]
                                               : 8'h00;
                    readValid_d = 1'b1;
                end
            end
        endcase
    end

    // state registers; reset returns to run state but not the array
    // the strap is retaken after every release, so a later change waits for reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q       <= config_access_pkg::RUN_STATE;
            rstSeen_q     <= 1'b0;
            baseLatched_q <= 1'b0;
            indexSelect_q <= `CFG_INDEX_RESET;
            readData_q    <= 8'h00;
            readValid_q   <= 1'b0;
        end
        else
        begin
            state_q       <= state_d;
            rstSeen_q     <= rstSeen_d;
            baseLatched_q <= baseLatched_d;
            indexSelect_q <= indexSelect_d;
            readData_q    <= readData_d;
            readValid_q   <= readValid_d;
        end
    end

    // register array: power-up defaults only, writes in config state
    genvar gi;
    generate
        for (gi = 0; gi < `CFG_REG_COUNT; gi++)
        begin : gen_cfg_reg
            // a byte loads only from a data-port write that selects it
            always_ff @(posedge clk)
            begin
                if (arrayWrite && indexSelect_q[5:0] == 6'(gi))
                begin
                    configRegisterArray[gi] <= wdataSync_q;
                end
            end
            assign configRegisterFlat[gi*8 +: 8] = configRegisterArray[gi];
        end
    endgenerate

    // outputs come straight from flops, so no decode glitch reaches them
    assign ioReadData        = readData_q;
    assign ioReadValid       = readValid_q;
    assign configActive      = (state_q == config_access_pkg::CONFIG_STATE);
    assign baseSelectLatched = baseLatched_q;

endmodule // config_access_state_machine

// [verif/host_bus_model.sv]
`timescale 1ns/1ps
// host side of the i/o bus: one strobed byte access at a time
module host_bus_model
(
    input  wire logic       clk,
    input  wire logic       ioReadValid,
    output logic      [9:0] ioAddr,
    output logic      [7:0] ioWriteData,
    output logic            ioWrite,
    output logic            ioRead
);
    initial {ioAddr, ioWriteData, ioWrite, ioRead} = '0;
    // setup and recovery of 3+ cycles cover the 2-flop input synchronisers
    task automatic acc(input logic rd, input logic [9:0] a, input logic [7:0] d,
                       output logic seen);
        seen = 1'b0;
        @(posedge clk) ioAddr <= a;
        ioWriteData <= d;
        repeat (3) @(posedge clk);
        ioRead <= rd;
        ioWrite <= !rd;
        repeat (7) @(posedge clk) seen |= ioReadValid;
        ioRead <= 1'b0;
        ioWrite <= 1'b0;
        ioAddr <= ~a; // released bus shows no stale value
        ioWriteData <= ~d;
        repeat (4) @(posedge clk);
    endtask
endmodule // host_bus_model

// [verif/config_access_chk.sv]
`timescale 1ns/1ps
module config_access_chk
(
    input wire logic         clk,
    input wire logic         rst,
    input wire logic [9:0]   ioAddr,
    input wire logic [7:0]   ioWriteData,
    input wire logic         ioWrite,
    input wire logic         ioReadValid,
    input wire logic         configActive,
    input wire logic         baseSelectLatched,
    input wire logic [383:0] configRegisterFlat
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // a write lands within 3 cycles of its strobe rising, so 5 quiet cycles means none in flight
    sequence s_noWrite; !ioWrite[*5]; endsequence
    property p_enter; $rose(configActive) |-> ioWrite && ioWriteData == 8'h55; endproperty
    a_enter: assert property (p_enter) else $error("entry without key");
    property p_exit; $fell(configActive) |-> ioWrite && ioWriteData == 8'hAA; endproperty
    a_exit: assert property (p_exit) else $error("exit without key");
    property p_hold; s_noWrite |-> $stable(configActive); endproperty
    a_hold: assert property (p_hold) else $error("state moved");
    property p_keep; s_noWrite |-> $stable(configRegisterFlat); endproperty
    a_keep: assert property (p_keep) else $error("array moved");
    property p_quiet; !configActive[*6] |-> !ioReadValid; endproperty
    a_quiet: assert property (p_quiet) else $error("read in run state");
    property p_port; ioReadValid |-> ioAddr[9:1] == (baseSelectLatched ? 9'h1B8 : 9'h1F8);
    endproperty
    a_port: assert property (p_port) else $error("wrong port");
    property p_strap; $past(!rst) && $past(!rst, 2) |-> $stable(baseSelectLatched); endproperty
    a_strap: assert property (p_strap) else $error("strap moved");
    property p_pulse; ioReadValid |=> !ioReadValid; endproperty
    a_pulse: assert property (p_pulse) else $error("long pulse");
endmodule // config_access_chk
bind config_access_state_machine config_access_chk chk (.clk(clk), .rst(rst), .ioAddr(ioAddr),
    .ioWriteData(ioWriteData), .ioWrite(ioWrite), .ioReadValid(ioReadValid),
    .configActive(configActive), .baseSelectLatched(baseSelectLatched),
    .configRegisterFlat(configRegisterFlat));

// [verif/test_config_access_state_machine.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin testsRun++; if ((a) !== (b)) begin badCount++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, (a), (b)); end end
module test_config_access_state_machine;
    logic         clk = 1'b0, rst = 1'b1, strap = 1'b0, vld, act, lat, seen, wr, rd;
    logic [9:0]   addr;
    logic [7:0]   wd, rdData;
    logic [383:0] regs;
    int           badCount = 0, testsRun = 0;
    logic [7:0]   idx [3] = '{8'h00, 8'h05, 8'h2F};
    // 10 MHz clock
    always #50 clk = ~clk;
    host_bus_model host (.clk(clk), .ioReadValid(vld), .ioAddr(addr), .ioWriteData(wd),
        .ioWrite(wr), .ioRead(rd));
    config_access_state_machine dut (.clk(clk), .rst(rst), .baseSelectStrap(strap),
        .ioAddr(addr), .ioWriteData(wd), .ioWrite(wr), .ioRead(rd), .ioReadData(rdData),
        .ioReadValid(vld), .configActive(act), .baseSelectLatched(lat),
        .configRegisterFlat(regs));
    // strap held steady around release so the synchroniser sees it
    task automatic reboot(input logic s);
        @(posedge clk) rst <= 1'b1;
        strap <= s;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic w(input logic [9:0] a, input logic [7:0] d);
        host.acc(1'b0, a, d, seen);
    endtask
    task automatic r(input logic [9:0] a, input logic v, input logic [7:0] d);
        host.acc(1'b1, a, 8'h00, seen);
        `CHK(seen, v)
        if (v)
        begin
            `CHK(rdData, d)
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // enter, program, read back, exit, then reset onto the other base
    initial
    begin
        reboot(1'b0);
        `CHK(lat, 1'b0)
        `CHK(act, 1'b0)
        r(10'h3F0, 1'b0, 8'h00);
        w(10'h3F0, 8'h55);
        `CHK(act, 1'b1)
        foreach (idx[i])
        begin
            w(10'h3F0, idx[i]);
            w(10'h3F1, idx[i] ^ 8'hA5);
        end
        foreach (idx[i])
        begin
            w(10'h3F0, idx[i]);
            r(10'h3F1, 1'b1, idx[i] ^ 8'hA5);
            r(10'h3F0, 1'b1, idx[i]);
            `CHK(regs[8 * idx[i] +: 8], idx[i] ^ 8'hA5)
        end
        w(10'h3F0, 8'h55);
        r(10'h3F0, 1'b1, 8'h55);
        w(10'h3F1, 8'h77);
        r(10'h3F1, 1'b1, 8'h00);
        `CHK(act, 1'b1)
        w(10'h3F0, 8'h05);
        w(10'h3F0, 8'hAA);
        `CHK(act, 1'b0)
        r(10'h3F1, 1'b0, 8'h00);
        w(10'h3F1, 8'h11);
        `CHK(regs[47:40], 8'hA0)
        reboot(1'b1);
        `CHK(lat, 1'b1)
        `CHK(regs[383:376], 8'h8A)
        w(10'h3F0, 8'h55);
        `CHK(act, 1'b0)
        w(10'h370, 8'h55);
        r(10'h371, 1'b1, 8'hA5);
        final_report;
    end
endmodule // test_config_access_state_machine
